/* logic/fault_readout_params.svh */
// Constants of the serial status readout: word codes, command fields, reset values.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef FAULT_READOUT_PARAMS_SVH
`define FAULT_READOUT_PARAMS_SVH

// ****************************************
// Output word codes, bits 15..12
// ****************************************
`define CODE_ALIAS_QUICK 4'h0
`define CODE_QUICK 4'h1
`define CODE_CH1 4'h2
`define CODE_CH4 4'h5
`define CODE_DEV 4'h7
`define CODE_IO 4'h8
`define CODE_ID 4'h9

// ****************************************
// Received command word layout
// ****************************************
`define CMD_ADDR_INIT1 4'h0
`define CMD_SEL_MSB 3
`define CMD_SEL_LSB 0
`define CMD_PERSIST_BIT 4

// ****************************************
// Reset values and framing
// ****************************************
`define RST_SEL 4'h1
`define RST_PERSIST 1'b0
`define RST_REGS_CLEARED 1'b1
`define FRAME_BITS 16
`define WORD_BITS 16
`define NUM_CHANNELS 4

`endif

/* logic/fault_readout_pkg.sv */
// Types shared by the serial status readout.
// Assumes nothing of its surroundings.
package fault_readout_pkg;

    typedef enum logic {
        LINK_IDLE,
        LINK_FRAME
    } link_state_e;

    typedef logic [3:0] word_code_t;

endpackage

/* logic/pin_sync.sv */
// Two-flop synchroniser for levels that arrive from pins.
// Assumes sys_clk and a synchronous active-low reset.
`timescale 1ns/1ps

module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out
);

    logic [WIDTH-1:0] meta_reg;

    generate
        if (WIDTH < 1) begin : g_chk
            $error("pin_sync WIDTH must be at least 1");
        end
    endgenerate

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            meta_reg <= RST_VAL;
            pin_out <= RST_VAL;
        end else begin
            meta_reg <= pin_in;
            pin_out <= meta_reg;
        end
    end

endmodule

/* logic/chan_fault_latch.sv */
// Latched fault bits of one output channel, cleared by a read of its status word.
// Assumes fault events come from logic on sys_clk, one cycle each or held.
`timescale 1ns/1ps

module chan_fault_latch (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic ots_event,
    input wire logic otw_event,
    input wire logic olon_event,
    input wire logic oloff_event,
    input wire logic oc_event,
    input wire logic [2:0] oc_code_in,
    input wire logic read_clr,
    output logic [6:0] status_bits,
    output logic chan_quick_flag,
    output logic overload,
    output logic openload
);

    logic overtemp_shutdown_reg;
    logic overtemp_warning_reg;
    logic openload_on_flag_reg;
    logic openload_off_flag_reg;
    logic [2:0] overcurrent_code_reg;

    // ****************************************
    // Sticky bits; a new event beats the read clear
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            overtemp_shutdown_reg <= 1'b0;
            overtemp_warning_reg <= 1'b0;
        end else begin
            overtemp_shutdown_reg <= ots_event | (overtemp_shutdown_reg & ~read_clr);
            overtemp_warning_reg <= otw_event | (overtemp_warning_reg & ~read_clr);
        end
    end

    // Open load held until this channel's word is read
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            openload_on_flag_reg <= 1'b0;
            openload_off_flag_reg <= 1'b0;
        end else begin
            openload_on_flag_reg <= olon_event | (openload_on_flag_reg & ~read_clr);
            openload_off_flag_reg <= oloff_event | (openload_off_flag_reg & ~read_clr);
        end
    end

    // Newest fault overwrites an unread one
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            overcurrent_code_reg <= 3'h0;
        end else if (oc_event) begin
            overcurrent_code_reg <= oc_code_in;
        end else if (read_clr) begin
            overcurrent_code_reg <= 3'h0;
        end
    end

    // Word bits 6..0, code msb first
    assign status_bits = {overtemp_shutdown_reg, overtemp_warning_reg, overcurrent_code_reg,
                          openload_on_flag_reg, openload_off_flag_reg};
    assign chan_quick_flag = |status_bits;
    assign overload = overtemp_shutdown_reg | (|overcurrent_code_reg);
    assign openload = openload_on_flag_reg | openload_off_flag_reg;

    // ****************************************
    // Checks
    // ****************************************
    oc_overwrite_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        oc_event |=> overcurrent_code_reg == $past(oc_code_in))
        else $error("overcurrent code not replaced by newest fault");

    openload_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (openload_off_flag_reg && !read_clr) |=> openload_off_flag_reg)
        else $error("open load flag dropped without a read");

    set_beats_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (read_clr && ots_event) |=> (overtemp_shutdown_reg && chan_quick_flag))
        else $error("shutdown event lost against read clear");

endmodule

/* logic/spi_fault_status_readout.sv */
// Serial status readout of a four-channel high-side switch: selects and shifts out
// one 16-bit diagnostic word per frame and clears latched faults on read.
// Assumes SPI pins arrive asynchronously, fault events come from logic on sys_clk.
//
// Behaviour
// - Persist 0: programmed word is read once, then quick word is selected again.
// - Persist 1: programmed word is returned on every read until reprogrammed.
// - Bits 15..12 carry the word code; selection 0 returns quick word, code 0001.
// - Quick word: fail, device, overload, open-load, pump, cleared, clock, unused, channels.
// - Bit 11 of every word shows fail mode.
// - Global flags in 10..8 clear only once reads clear all underlying bits.
// - Device fault sum ORs cleared, under-, overvoltage, pump, clock-fail, test-mode.
// - Overload sum ORs all channel overcurrent and overtemperature-shutdown bits.
// - Registers-cleared flag is set whenever all serial registers are reset.
// - Channel quick flag ORs that channel's overcurrent, thermal and open-load bits.
// - Channel words, codes 0010..0101: reserved, shutdown, warning, code, open-load bits.
// - Overcurrent code reports newest fault, overwriting an unread one.
// - Device word, code 0111: test-mode, over-, undervoltage, link fail, limp input.
// - Limp input bit is live synchronised level, never latched.
// - Pin word, code 1000: toggle, inputs 4..1, output comparators 4..1, live.
// - Toggle bit ORs the four input toggle signals.
// - Output state bits valid only without undervoltage.
// - Identification word, code 1001: part code, all zeros under undervoltage.
// - Latched open-load bits release only on a read of that channel word.
`timescale 1ns/1ps
`include "fault_readout_params.svh"

module spi_fault_status_readout #(
    parameter int FRAME_BITS = `FRAME_BITS,
    parameter int NUM_CHANNELS = `NUM_CHANNELS,
    parameter logic [7:0] PART_CODE = 8'h5A // Arbitrary value
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic spi_sclk,
    input wire logic spi_cs_b,
    input wire logic spi_si,
    output logic spi_so,
    output logic spi_so_en,
    input wire logic failmode_ind,
    input wire logic [3:0] overtemp_shutdown,
    input wire logic [3:0] overtemp_warning,
    input wire logic [3:0] openload_on_flag,
    input wire logic [3:0] openload_off_flag,
    input wire logic [3:0] overcurrent_event,
    input wire logic [11:0] overcurrent_code,
    input wire logic charge_pump_fault,
    input wire logic clock_fail_flag,
    input wire logic overvoltage_flag,
    input wire logic undervoltage_flag,
    input wire logic test_mode_flag,
    input wire logic limp_input_state,
    input wire logic [3:0] input_pin_state,
    input wire logic [3:0] output_pin_state,
    input wire logic [3:0] input_toggle
);

    localparam int CW = $clog2(FRAME_BITS + 1);
    localparam int WB = `WORD_BITS;

    // ****************************************
    // Elaboration checks
    // ****************************************
    generate
        if (FRAME_BITS < WB) begin : g_chk_frame
            $error("FRAME_BITS shorter than one output word");
        end
        if (NUM_CHANNELS != `NUM_CHANNELS) begin : g_chk_chan
            $error("word layout serves exactly four channels");
        end
    endgenerate

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [2:0] link_s;
    logic [8:0] live_s;
    logic cs_s;
    logic sclk_s;
    logic si_s;
    logic sclk_d_reg;

    pin_sync #(.WIDTH(3), .RST_VAL(3'b100)) u_link_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .pin_in({spi_cs_b, spi_sclk, spi_si}),
        .pin_out(link_s)
    );

    // Live levels are sampled only, never held
    pin_sync #(.WIDTH(9), .RST_VAL(9'h000)) u_live_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .pin_in({limp_input_state, input_pin_state, output_pin_state}),
        .pin_out(live_s)
    );

    assign cs_s = link_s[2];
    assign sclk_s = link_s[1];
    assign si_s = link_s[0];

    // ****************************************
    // Frame tracking
    // ****************************************
    fault_readout_pkg::link_state_e link_state_reg;
    logic frame_start;
    logic frame_end;
    logic frame_ok;
    logic sclk_rise;
    logic sclk_fall;
    logic [CW-1:0] bit_cnt_reg;
    logic [WB-1:0] rx_reg;
    logic [WB-1:0] so_shift_reg;
    fault_readout_pkg::word_code_t sent_code_reg;

    assign frame_start = (link_state_reg == fault_readout_pkg::LINK_IDLE) && !cs_s;
    assign frame_end = (link_state_reg == fault_readout_pkg::LINK_FRAME) && cs_s;
    assign sclk_rise = (link_state_reg == fault_readout_pkg::LINK_FRAME) && sclk_s && !sclk_d_reg;
    assign sclk_fall = (link_state_reg == fault_readout_pkg::LINK_FRAME) && !sclk_s && sclk_d_reg;
    // Short or long frames are not reads: no clear, no change of selection
    assign frame_ok = frame_end && (bit_cnt_reg == CW'(FRAME_BITS));

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            link_state_reg <= fault_readout_pkg::LINK_IDLE;
        end else begin
            case (link_state_reg)
                fault_readout_pkg::LINK_IDLE: begin
                    if (!cs_s) begin
                        link_state_reg <= fault_readout_pkg::LINK_FRAME;
                    end
                end
                fault_readout_pkg::LINK_FRAME: begin
                    if (cs_s) begin
                        link_state_reg <= fault_readout_pkg::LINK_IDLE;
                    end
                end
                default: begin
                    link_state_reg <= fault_readout_pkg::LINK_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            sclk_d_reg <= 1'b0;
        end else begin
            sclk_d_reg <= sclk_s;
        end
    end

    // Counter saturates one above the frame so overruns stay visible
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            bit_cnt_reg <= '0;
            rx_reg <= 16'h0000;
        end else if (frame_start) begin
            bit_cnt_reg <= '0;
        end else if (sclk_rise) begin
            rx_reg <= {rx_reg[WB-2:0], si_s};
            if (bit_cnt_reg <= CW'(FRAME_BITS)) begin
                bit_cnt_reg <= bit_cnt_reg + CW'(1);
            end
        end
    end

    // ****************************************
    // Word selection
    // ****************************************
    fault_readout_pkg::word_code_t out_word_select_reg;
    logic out_word_persist_reg;
    logic cmd_write;

    assign cmd_write = frame_ok && (rx_reg[WB-1:WB-4] == `CMD_ADDR_INIT1);

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            out_word_select_reg <= `RST_SEL;
            out_word_persist_reg <= `RST_PERSIST;
        end else if (cmd_write) begin
            out_word_select_reg <= rx_reg[`CMD_SEL_MSB:`CMD_SEL_LSB];
            out_word_persist_reg <= rx_reg[`CMD_PERSIST_BIT];
        end else if (frame_ok && !out_word_persist_reg) begin
            out_word_select_reg <= `RST_SEL;
        end
        // Persist set: selection only moves on a new command
    end

    // ****************************************
    // Channel latches
    // ****************************************
    logic [6:0] chan_bits [NUM_CHANNELS];
    logic [NUM_CHANNELS-1:0] chan_quick_flag;
    logic [NUM_CHANNELS-1:0] chan_overload;
    logic [NUM_CHANNELS-1:0] chan_openload;
    logic [NUM_CHANNELS-1:0] chan_clr;

    generate
        for (genvar i = 0; i < NUM_CHANNELS; i++) begin : g_chan
            // Reading a channel word releases that channel only
            assign chan_clr[i] = frame_ok && (sent_code_reg == (`CODE_CH1 + 4'(i)));
            chan_fault_latch u_latch (
                .sys_clk(sys_clk),
                .rst_b(rst_b),
                .ots_event(overtemp_shutdown[i]),
                .otw_event(overtemp_warning[i]),
                .olon_event(openload_on_flag[i]),
                .oloff_event(openload_off_flag[i]),
                .oc_event(overcurrent_event[i]),
                .oc_code_in(overcurrent_code[3*i +: 3]),
                .read_clr(chan_clr[i]),
                .status_bits(chan_bits[i]),
                .chan_quick_flag(chan_quick_flag[i]),
                .overload(chan_overload[i]),
                .openload(chan_openload[i])
            );
        end
    endgenerate

    // ****************************************
    // Device flags
    // ****************************************
    // Order: test-mode, over-, undervoltage, pump, clock fail, link fail
    logic [5:0] dev_flags_reg;
    logic [5:0] dev_evt;
    logic regs_cleared_flag_reg;
    logic dev_clr;
    logic device_fault_sum;
    logic overload_sum;
    logic openload_sum;

    assign dev_clr = frame_ok && (sent_code_reg == `CODE_DEV);
    assign dev_evt = {test_mode_flag, overvoltage_flag, undervoltage_flag, charge_pump_fault,
                      clock_fail_flag, frame_end && !frame_ok};

    // Event wins over the read clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            dev_flags_reg <= 6'h00;
        end else begin
            dev_flags_reg <= dev_evt | (dev_flags_reg & ~{6{dev_clr}});
        end
    end

    // Reset of every serial register raises this flag
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            regs_cleared_flag_reg <= `RST_REGS_CLEARED;
        end else if (dev_clr) begin
            regs_cleared_flag_reg <= 1'b0;
        end
    end

    // Sums follow the latched bits, so they fall only once reads clear them
    assign device_fault_sum = regs_cleared_flag_reg | (|dev_flags_reg[5:1]);
    assign overload_sum = |chan_overload;
    assign openload_sum = |chan_openload;

    // ****************************************
    // Word assembly
    // ****************************************
    fault_readout_pkg::word_code_t eff_code;
    logic [2:0] global_flags;
    logic [WB-1:0] quick_word;
    logic [WB-1:0] out_word;
    logic [1:0] ch_idx;
    logic [7:0] id_bits;
    logic [3:0] out_state;

    // Selection 0 aliases the quick word
    assign eff_code = (out_word_select_reg == `CODE_ALIAS_QUICK) ? `CODE_QUICK
                                                                 : out_word_select_reg;
    assign global_flags = {device_fault_sum, overload_sum, openload_sum};
    assign ch_idx = 2'(eff_code - `CODE_CH1);
    // Identification blanked under undervoltage
    assign id_bits = dev_flags_reg[3] ? 8'h00 : PART_CODE;
    // Comparators meaningless without supply, so reported low
    assign out_state = dev_flags_reg[3] ? 4'h0 : live_s[3:0];

    // Unused bit 4 reads zero
    assign quick_word = {`CODE_QUICK, failmode_ind, global_flags, dev_flags_reg[2],
                         regs_cleared_flag_reg, dev_flags_reg[1], 1'b0,
                         chan_quick_flag[3], chan_quick_flag[2], chan_quick_flag[1],
                         chan_quick_flag[0]};

    // Fail mode in bit 11 of every word
    always_comb begin
        out_word = quick_word;
        if (eff_code >= `CODE_CH1 && eff_code <= `CODE_CH4) begin
            out_word = {eff_code, failmode_ind, global_flags, 1'b0, chan_bits[ch_idx]};
        end else begin
            case (eff_code)
                `CODE_DEV: begin
                    out_word = {`CODE_DEV, failmode_ind, global_flags, 3'h0,
                                dev_flags_reg[5:3], dev_flags_reg[0], live_s[8]};
                end
                `CODE_IO: begin
                    out_word = {`CODE_IO, failmode_ind, 1'b0, |input_toggle,
                                live_s[7:4], 1'b0, out_state};
                end
                `CODE_ID: begin
                    out_word = {`CODE_ID, failmode_ind, 3'h0, id_bits};
                end
                default: begin
                    out_word = quick_word;
                end
            endcase
        end
    end

    // ****************************************
    // Serial output
    // ****************************************
    // Word is frozen at frame start so mid-frame events cannot tear it
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            so_shift_reg <= 16'h0000;
            sent_code_reg <= `CODE_QUICK;
        end else if (frame_start) begin
            so_shift_reg <= out_word;
            sent_code_reg <= eff_code;
        end else if (sclk_fall) begin
            so_shift_reg <= {so_shift_reg[WB-2:0], 1'b0};
        end
    end

    assign spi_so = so_shift_reg[WB-1];
    assign spi_so_en = (link_state_reg == fault_readout_pkg::LINK_FRAME);

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    one_shot_revert_a: assert property (
        (frame_ok && !cmd_write && !out_word_persist_reg) |=> out_word_select_reg == `RST_SEL)
        else $error("selection did not return to quick word");

    persist_hold_a: assert property (
        (frame_ok && !cmd_write && out_word_persist_reg) |=> $stable(out_word_select_reg))
        else $error("persistent selection changed without command");

    code_field_a: assert property (
        frame_start |=> so_shift_reg[15:12] == (($past(out_word_select_reg) inside {4'h2, 4'h3,
            4'h4, 4'h5, 4'h7, 4'h8, 4'h9}) ? $past(out_word_select_reg) : 4'h1))
        else $error("loaded word carries wrong code");

    fail_bit_a: assert property (
        frame_start |=> so_shift_reg[11] == $past(failmode_ind))
        else $error("fail mode bit wrong in loaded word");

    dev_sum_a: assert property (
        (frame_start && eff_code == `CODE_QUICK) ##1 1'b1 |-> so_shift_reg[10] ==
            $past(regs_cleared_flag_reg | dev_flags_reg[5] | dev_flags_reg[4] |
                  dev_flags_reg[3] | dev_flags_reg[2] | dev_flags_reg[1]))
        else $error("device fault sum wrong in quick word");

    overload_a: assert property (
        $rose(|overtemp_shutdown) |=> overload_sum)
        else $error("overload sum missed a shutdown");

    cleared_after_reset_a: assert property (
        $past(!rst_b) |-> (regs_cleared_flag_reg && device_fault_sum))
        else $error("registers-cleared flag not set after reset");

    id_blank_a: assert property (
        (frame_start && eff_code == `CODE_ID && dev_flags_reg[3]) |=> so_shift_reg[7:0] == 8'h00)
        else $error("identification not blanked under undervoltage");

    dev_clear_a: assert property (
        (dev_clr && dev_evt == 6'h00) |=> (dev_flags_reg == 6'h00 && !regs_cleared_flag_reg))
        else $error("device flags not cleared by read");

    io_live_a: assert property (
        (frame_start && eff_code == `CODE_IO) |=> so_shift_reg[8:5] == $past(live_s[7:4]))
        else $error("pin word inputs not live");

    persist_read_c: cover property (frame_ok && out_word_persist_reg && !cmd_write);
    chan_clear_c: cover property (|chan_clr);
    bad_frame_c: cover property (frame_end && !frame_ok);
    dev_read_c: cover property (dev_clr);

endmodule

/* sim/spi_master_model.sv */
// SPI master model: 16-bit mode 0 frames, msb first.
// Assumes the caller enters xfer just after a falling sys_clk edge.
`timescale 1ns/1ps

module spi_master_model (
    input wire logic sys_clk,
    input wire logic spi_so,
    output logic spi_sclk,
    output logic spi_cs_b,
    output logic spi_si
);
    // ****
    // Framing
    // ****
    initial begin
        spi_sclk = 1'b0;
        spi_cs_b = 1'b1;
        spi_si = 1'b0;
    end

    // Four cycles a phase, above the sync minimum
    task automatic w4();
        repeat (4) @(negedge sys_clk);
    endtask

    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        spi_cs_b = 1'b0;
        w4();
        for (int i = 15; i >= 0; i--) begin
            spi_si = tx[i];
            w4();
            rx[i] = spi_so;
            spi_sclk = 1'b1;
            w4();
            spi_sclk = 1'b0;
        end
        w4();
        spi_cs_b = 1'b1;
        // Released line flips, so a stale bit is never seen
        spi_si = ~spi_si;
        w4();
        w4();
    endtask
endmodule

/* sim/tb_spi_fault_status_readout.sv */
// Testbench of the status readout: framed reads with expected words.
// Assumes the design and the master model are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, g, e); end end

module tb_spi_fault_status_readout;
    // ****
    // Stimulus
    // ****
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic fm = 1'b0;
    logic limp = 1'b0;
    logic sclk, cs_b, si, so, so_en;
    logic [3:0] ots = '0, otw = '0, olon = '0, oloff = '0, oce = '0;
    logic [3:0] inp = '0, outp = '0, tog = '0;
    logic [11:0] occ = '0;
    logic [4:0] dev = '0;
    int num_errors = 0;
    int n_tests = 0;

    always #2.5 sys_clk = ~sys_clk;

    spi_fault_status_readout spi_fault_status_readout_i (.sys_clk(sys_clk), .rst_b(rst_b),
        .spi_sclk(sclk), .spi_cs_b(cs_b), .spi_si(si), .spi_so(so), .spi_so_en(so_en),
        .failmode_ind(fm), .overtemp_shutdown(ots), .overtemp_warning(otw),
        .openload_on_flag(olon), .openload_off_flag(oloff), .overcurrent_event(oce),
        .overcurrent_code(occ), .charge_pump_fault(dev[0]), .clock_fail_flag(dev[1]),
        .overvoltage_flag(dev[2]), .undervoltage_flag(dev[3]), .test_mode_flag(dev[4]),
        .limp_input_state(limp), .input_pin_state(inp), .output_pin_state(outp),
        .input_toggle(tog));

    spi_master_model spi_master_model_i (.sys_clk(sys_clk), .spi_so(so), .spi_sclk(sclk),
        .spi_cs_b(cs_b), .spi_si(si));

    // ****
    // Tasks
    // ****
    task automatic rd(input logic [15:0] tx, input logic [15:0] exp);
        logic [15:0] rx;
        fork
            spi_master_model_i.xfer(tx, rx);
            begin
                repeat (8) @(negedge sys_clk);
                `CHK(so_en, 1'b1)
            end
        join
        `CHK(rx, exp)
        `CHK(so_en, 1'b0)
    endtask

    task automatic reset_dut();
        rst_b = 1'b0;
        repeat (2) @(negedge sys_clk);
        rst_b = 1'b1;
        @(negedge sys_clk);
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ****
    // Tests, address F is a plain read
    // ****
    initial begin
        reset_dut();
        rd(16'hF000, 16'h1440);
        rd(16'h0007, 16'h1440);
        rd(16'hF000, 16'h7400);
        rd(16'hF000, 16'h1000);
        $display("test quick done");
        occ[5:3] = 3'b010;
        oce[1] = 1'b1;
        otw[1] = 1'b1;
        olon[2] = 1'b1;
        @(negedge sys_clk);
        occ[5:3] = 3'b110;
        {otw, olon} = '0;
        @(negedge sys_clk);
        oce = '0;
        rd(16'hF000, 16'h1306);
        rd(16'h0013, 16'h1306);
        rd(16'hF000, 16'h3338);
        rd(16'h0004, 16'h3100);
        rd(16'hF000, 16'h4102);
        rd(16'hF000, 16'h1000);
        $display("test channel done");
        {fm, limp, inp, outp, tog} = {2'b11, 12'hA52};
        rd(16'h0018, 16'h1800);
        rd(16'h0007, 16'h8B45);
        rd(16'h0009, 16'h7801);
        rd(16'hF000, 16'h985A);
        dev = 5'h18;
        @(negedge sys_clk);
        dev = '0;
        rd(16'h0009, 16'h1C00);
        rd(16'h0007, 16'h9800);
        rd(16'hF000, 16'h7C15);
        reset_dut();
        rd(16'hF000, 16'h1C40);
        $display("test device done");
        rd(16'h0016, 16'h1C40);
        {ots[0], oloff[3], dev[2:0]} = 5'h1F;
        spi_master_model_i.spi_cs_b = 1'b0;
        @(negedge sys_clk);
        {ots[0], oloff[3], dev[2:0]} = 5'h00;
        repeat (8) @(negedge sys_clk);
        spi_master_model_i.spi_cs_b = 1'b1;
        repeat (8) @(negedge sys_clk);
        rd(16'h0002, 16'h1FE9);
        rd(16'hF000, 16'h2F40);
        rd(16'h0017, 16'h1DE8);
        rd(16'hF000, 16'h7D0B);
        rd(16'hF000, 16'h7901);
        $display("test fault mix done");
        wrap_up();
    end

    initial begin
        #50us;
        num_errors++;
        wrap_up();
    end
endmodule
